/* File: verilog/servo_io_map.svh */
`ifndef SERVO_IO_MAP_SVH
`define SERVO_IO_MAP_SVH
// ****************************************
// terminal active-logic codes
// ****************************************
`define CODE_LOW 3'h0
`define CODE_HIGH 3'h1
`define CODE_RISE 3'h2
`define CODE_FALL 3'h3
`define CODE_BOTH 3'h4
// ****************************************
// override kinds for a terminal conditioner
// ****************************************
`define FORCE_NONE 2'h0
`define FORCE_LEVEL 2'h1
`define FORCE_EDGE 2'h2
// ****************************************
// mode selector values
// ****************************************
`define SPD_LIMIT_SRC_TERMINAL 3'h2
`define PULSE_SRC_PULSE_INPUT 2'h0
// ****************************************
// halt state codes, one-hot
// ****************************************
`define HALT_RUN_CODE 3'h1
`define HALT_STOP_CODE 3'h2
`define HALT_LOCK_CODE 3'h4
`endif

/* File: verilog/servo_io_pkg.sv */
`include "servo_io_map.svh"
package servo_io_pkg;
   // active-logic setting of one terminal
   typedef logic [2:0] logic_code_t;
   // emergency halt sequence
   typedef enum logic [2:0] {
      HALT_RUN = `HALT_RUN_CODE,
      HALT_STOP = `HALT_STOP_CODE,
      HALT_LOCK = `HALT_LOCK_CODE
   } halt_state_t;
endpackage : servo_io_pkg

/* File: verilog/term_if.sv */
`timescale 1ns/100ps
// conditioned view of one digital terminal
interface term_if;
   servo_io_pkg::logic_code_t code_eff; // logic setting after override
   logic level; // active for level settings
   logic pulse; // one cycle on an active edge
   modport drv (output code_eff, output level, output pulse);
   modport sink (input code_eff, input level, input pulse);
endinterface : term_if

/* File: verilog/term_cond.sv */
`timescale 1ns/100ps
`include "servo_io_map.svh"
// ****************************************
// terminal conditioner: sync, override, detect
// ****************************************
module term_cond #(
   parameter logic [1:0] FORCE_KIND = `FORCE_NONE
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic term_raw,
   input wire servo_io_pkg::logic_code_t code_cfg,
   term_if.drv tio
);
   logic s1_q; // first sync stage, read by s2 only
   logic s2_q; // synchronised level
   logic s3_q; // previous synchronised level
   servo_io_pkg::logic_code_t eff; // overridden setting

   // two-stage synchroniser plus history flop
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else if (clk_en) begin
         s1_q <= term_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // forced rewrite of the logic setting
   always_comb begin
      eff = code_cfg;
      if (FORCE_KIND == `FORCE_LEVEL) begin
         // edge settings become levels
         if (code_cfg == `CODE_RISE) begin
            eff = `CODE_HIGH;
         end else if (code_cfg == `CODE_FALL || code_cfg == `CODE_BOTH) begin
            eff = `CODE_LOW;
         end
      end else if (FORCE_KIND == `FORCE_EDGE) begin
         // level settings become edges
         if (code_cfg == `CODE_HIGH) begin
            eff = `CODE_RISE;
         end else if (code_cfg == `CODE_LOW) begin
            eff = `CODE_FALL;
         end
      end
   end

   // level and edge evaluation on synchronised samples
   always_comb begin
      tio.code_eff = eff;
      tio.level = 1'b0;
      tio.pulse = 1'b0;
      case (eff)
         `CODE_LOW: tio.level = ~s2_q;
         `CODE_HIGH: tio.level = s2_q;
         `CODE_RISE: tio.pulse = s2_q & ~s3_q;
         `CODE_FALL: tio.pulse = ~s2_q & s3_q;
         `CODE_BOTH: tio.pulse = s2_q ^ s3_q;
         default: tio.level = 1'b0; // unused codes never act
      endcase
   end
endmodule : term_cond

/* File: verilog/servo_io_function_logic.sv */
// Summary of operation
// - home switch edge settings forced to levels
// - halt input stops, then locks position
// - deviation clear level settings forced to edges
// - clear edge zeroes accumulated position deviation
// - terminal picks negated speed limit parameter
// - pulse block ignores pulses in pulse mode
// - ready only when servo-on can be accepted
// - ready off on class 1/2 fault, halt
// - rotation output when speed exceeds threshold
// - direction select keeps or inverts position reference
`timescale 1ns/100ps
`include "servo_io_map.svh"
module servo_io_function_logic #(
   parameter int SPEED_W = 16,
   parameter int DEV_W = 32,
   parameter int REF_W = 32
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic position_direction_select,
   input wire servo_io_pkg::logic_code_t position_direction_code,
   input wire logic homing_switch_input,
   input wire servo_io_pkg::logic_code_t homing_switch_code,
   input wire logic emergency_halt_input,
   input wire servo_io_pkg::logic_code_t emergency_halt_code,
   input wire logic deviation_clear_input,
   input wire servo_io_pkg::logic_code_t deviation_clear_code,
   input wire logic speed_limit_source_select,
   input wire servo_io_pkg::logic_code_t speed_limit_source_code,
   input wire logic pulse_input_block,
   input wire servo_io_pkg::logic_code_t pulse_input_block_code,
   input wire logic [2:0] speed_limit_source_mode,
   input wire logic signed [SPEED_W-1:0] speed_limit_first,
   input wire logic signed [SPEED_W-1:0] speed_limit_second,
   input wire logic position_mode,
   input wire logic [1:0] position_ref_source,
   input wire logic pulse_step_in,
   input wire logic signed [REF_W-1:0] position_ref_in,
   input wire logic signed [DEV_W-1:0] deviation_delta,
   input wire logic servo_on_possible,
   input wire logic fault_class1,
   input wire logic fault_class2,
   input wire logic signed [SPEED_W-1:0] motor_speed,
   input wire logic [SPEED_W-1:0] rotation_threshold,
   output logic signed [REF_W-1:0] position_ref_out_q,
   output logic homing_triggered_q,
   output logic halt_decel_q,
   output logic position_lock_q,
   output logic signed [DEV_W-1:0] deviation_accum_q,
   output logic deviation_cleared_q,
   output logic signed [SPEED_W-1:0] internal_speed_limit_q,
   output logic speed_limit_from_terminal_q,
   output logic pulse_accept_q,
   output logic servo_ready_q,
   output logic motor_rotating_output
);
   // ****************************************
   // terminal conditioning
   // ****************************************
   term_if dir_if (); // position direction select
   term_if home_if (); // homing switch
   term_if halt_if (); // emergency halt
   term_if dev_if (); // deviation clear
   term_if lim_if (); // speed limit source select
   term_if blk_if (); // pulse input block

   term_cond #(.FORCE_KIND(`FORCE_NONE)) u_dir (
      .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .term_raw(position_direction_select), .code_cfg(position_direction_code),
      .tio(dir_if.drv)
   );
   term_cond #(.FORCE_KIND(`FORCE_LEVEL)) u_home (
      .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .term_raw(homing_switch_input), .code_cfg(homing_switch_code),
      .tio(home_if.drv)
   );
   term_cond #(.FORCE_KIND(`FORCE_NONE)) u_halt (
      .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .term_raw(emergency_halt_input), .code_cfg(emergency_halt_code),
      .tio(halt_if.drv)
   );
   term_cond #(.FORCE_KIND(`FORCE_EDGE)) u_dev (
      .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .term_raw(deviation_clear_input), .code_cfg(deviation_clear_code),
      .tio(dev_if.drv)
   );
   term_cond #(.FORCE_KIND(`FORCE_NONE)) u_lim (
      .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .term_raw(speed_limit_source_select), .code_cfg(speed_limit_source_code),
      .tio(lim_if.drv)
   );
   term_cond #(.FORCE_KIND(`FORCE_NONE)) u_blk (
      .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .term_raw(pulse_input_block), .code_cfg(pulse_input_block_code),
      .tio(blk_if.drv)
   );

   // ****************************************
   // emergency halt sequence
   // ****************************************
   servo_io_pkg::halt_state_t state_q; // halt state
   servo_io_pkg::halt_state_t state_d; // next halt state
   logic [SPEED_W-1:0] spd_abs; // magnitude of measured speed

   // speed magnitude, minimum value maps to its unsigned weight
   assign spd_abs = motor_speed[SPEED_W-1] ? (~motor_speed + 1'b1) : motor_speed;

   // next state of the halt sequence
   always_comb begin
      state_d = state_q;
      case (state_q)
         servo_io_pkg::HALT_RUN: begin
            if (halt_if.level) begin
               state_d = servo_io_pkg::HALT_STOP;
            end
         end
         servo_io_pkg::HALT_STOP: begin
            if (!halt_if.level) begin
               state_d = servo_io_pkg::HALT_RUN;
            end else if (!motor_rotating_output) begin
               state_d = servo_io_pkg::HALT_LOCK;
            end
         end
         servo_io_pkg::HALT_LOCK: begin
            if (!halt_if.level) begin
               state_d = servo_io_pkg::HALT_RUN;
            end
         end
         default: state_d = servo_io_pkg::HALT_RUN; // recover from bad code
      endcase
   end

   // halt state register and its decoded outputs
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= servo_io_pkg::HALT_RUN;
         halt_decel_q <= 1'b0;
         position_lock_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         halt_decel_q <= (state_d == servo_io_pkg::HALT_STOP);
         position_lock_q <= (state_d == servo_io_pkg::HALT_LOCK);
      end
   end

   // ****************************************
   // status outputs
   // ****************************************
   // ready and rotation flags
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         servo_ready_q <= 1'b0;
         motor_rotating_output <= 1'b0;
         homing_triggered_q <= 1'b0;
      end else if (clk_en) begin
         // ready blocked by faults and halt
         servo_ready_q <= servo_on_possible & ~fault_class1 & ~fault_class2
                          & ~halt_if.level;
         motor_rotating_output <= (spd_abs > rotation_threshold);
         homing_triggered_q <= home_if.level;
      end
   end

   // ****************************************
   // position path
   // ****************************************
   // deviation accumulator with edge clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         deviation_accum_q <= '0;
         deviation_cleared_q <= 1'b0;
      end else if (clk_en) begin
         deviation_cleared_q <= dev_if.pulse;
         if (dev_if.pulse) begin
            deviation_accum_q <= '0;
         end else begin
            deviation_accum_q <= deviation_accum_q + deviation_delta;
         end
      end
   end

   // reference direction and pulse gating
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         position_ref_out_q <= '0;
         pulse_accept_q <= 1'b0;
      end else if (clk_en) begin
         // inactive select inverts the given direction
         position_ref_out_q <= dir_if.level ? position_ref_in : -position_ref_in;
         // block applies only in position mode on pulse source
         pulse_accept_q <= pulse_step_in & ~(position_mode & blk_if.level
                           & (position_ref_source == `PULSE_SRC_PULSE_INPUT));
      end
   end

   // ****************************************
   // internal speed limit source
   // ****************************************
   // active terminal picks first parameter, inactive the second
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         internal_speed_limit_q <= '0;
         speed_limit_from_terminal_q <= 1'b0;
      end else if (clk_en) begin
         if (speed_limit_source_mode == `SPD_LIMIT_SRC_TERMINAL) begin
            speed_limit_from_terminal_q <= 1'b1;
            internal_speed_limit_q <= lim_if.level ? -speed_limit_first
                                                   : -speed_limit_second;
         end else begin
            speed_limit_from_terminal_q <= 1'b0;
            internal_speed_limit_q <= '0;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence s_halt_hit;
      clk_en && halt_if.level && state_q == servo_io_pkg::HALT_RUN;
   endsequence
   sequence s_halt_still;
      clk_en && halt_if.level && state_q == servo_io_pkg::HALT_STOP && !motor_rotating_output;
   endsequence

   property p_home_level;
      home_if.code_eff == `CODE_LOW || home_if.code_eff == `CODE_HIGH
         || home_if.code_eff > `CODE_BOTH;
   endproperty
   a_home_level: assert property (p_home_level) else $error("home setting is edge");

   property p_dev_edge;
      dev_if.code_eff != `CODE_LOW && dev_if.code_eff != `CODE_HIGH;
   endproperty
   a_dev_edge: assert property (p_dev_edge) else $error("clear setting is level");

   property p_halt_stop;
      s_halt_hit |=> halt_decel_q && !position_lock_q;
   endproperty
   a_halt_stop: assert property (p_halt_stop) else $error("halt did not stop");

   property p_halt_lock;
      s_halt_still |=> position_lock_q && !halt_decel_q;
   endproperty
   a_halt_lock: assert property (p_halt_lock) else $error("halt did not lock");

   property p_halt_release;
      clk_en && !halt_if.level |=> state_q == servo_io_pkg::HALT_RUN && !position_lock_q;
   endproperty
   a_halt_release: assert property (p_halt_release) else $error("halt not released");

   property p_dev_clear;
      clk_en && dev_if.pulse |=> deviation_accum_q == '0 && deviation_cleared_q;
   endproperty
   a_dev_clear: assert property (p_dev_clear) else $error("deviation not cleared");

   property p_dev_hold;
      clk_en && !dev_if.pulse && deviation_delta == '0 |=> $stable(deviation_accum_q);
   endproperty
   a_dev_hold: assert property (p_dev_hold) else $error("deviation changed");

   property p_ready;
      clk_en |=> servo_ready_q == ($past(servo_on_possible) && !$past(fault_class1)
                 && !$past(fault_class2) && !$past(halt_if.level));
   endproperty
   a_ready: assert property (p_ready) else $error("ready wrong");

   property p_rotate;
      clk_en |=> motor_rotating_output == ($past(spd_abs) > $past(rotation_threshold));
   endproperty
   a_rotate: assert property (p_rotate) else $error("rotation flag wrong");

   property p_pulse_block;
      clk_en && position_mode && blk_if.level
         && position_ref_source == `PULSE_SRC_PULSE_INPUT |=> !pulse_accept_q;
   endproperty
   a_pulse_block: assert property (p_pulse_block) else $error("blocked pulse passed");

   property p_dir;
      clk_en && !dir_if.level |=> position_ref_out_q == -$past(position_ref_in);
   endproperty
   a_dir: assert property (p_dir) else $error("direction not inverted");

   property p_limit;
      clk_en && speed_limit_source_mode == `SPD_LIMIT_SRC_TERMINAL && lim_if.level
         |=> internal_speed_limit_q == -$past(speed_limit_first);
   endproperty
   a_limit: assert property (p_limit) else $error("speed limit source wrong");
endmodule : servo_io_function_logic

/* File: verification/field_terminal_model.sv */
`timescale 1ns/100ps
// ****
// field switch and host terminal model
// ****
module field_terminal_model (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [5:0] want,
   output logic [5:0] term
);
   // home kept on a level code, clear on terminal eight or nine, outside here
   // contact levels follow the bench request one edge later
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         term <= 6'h00;
      end else begin
         term <= want;
      end
   end
endmodule : field_terminal_model

/* File: verification/servo_io_function_logic_tb_top.sv */
`timescale 1ns/100ps
// ****
// self-checking bench
// ****
module servo_io_function_logic_tb_top;
   localparam int SW = 16;
   localparam int DW = 32;
   localparam int RW = 32;
   logic core_clk = 1'h0;
   logic nrst = 1'h0;
   logic clk_en = 1'h1; // running, dropped low for the clock enable test
   logic [5:0] want = 6'h00; // terminal requests: dir home halt clear limit block
   logic [5:0] term;
   servo_io_pkg::logic_code_t dir_c = 3'h1;
   servo_io_pkg::logic_code_t home_c = 3'h1;
   servo_io_pkg::logic_code_t halt_c = 3'h1;
   servo_io_pkg::logic_code_t clr_c = 3'h2;
   servo_io_pkg::logic_code_t sls_c = 3'h1;
   servo_io_pkg::logic_code_t blk_c = 3'h1;
   logic [2:0] sl_mode = 3'h0;
   logic signed [SW-1:0] lim_a = 16'h0000;
   logic signed [SW-1:0] lim_b = 16'h0000;
   logic pos_mode = 1'h0;
   logic [1:0] ref_src = 2'h0;
   logic pulse = 1'h0;
   logic signed [RW-1:0] ref_in = 32'h0000_0000;
   logic signed [DW-1:0] delta = 32'h0000_0000;
   logic sop = 1'h0;
   logic f1 = 1'h0;
   logic f2 = 1'h0;
   logic signed [SW-1:0] speed = 16'h0000;
   logic [SW-1:0] thr = 16'h0000;
   // design outputs
   logic signed [RW-1:0] ref_out;
   logic signed [DW-1:0] acc_q;
   logic signed [SW-1:0] lim_q;
   logic home_q, decel_q, lock_q, clr_q, lim_t, acc_p, rdy_q, rot;
   // bench state
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   int n_clr = 0;
   int n_acc = 0;
   logic signed [DW-1:0] exp_acc;
   logic signed [SW-1:0] e_lim;
   logic signed [SW-1:0] sv;
   logic [SW-1:0] tv;
   servo_io_function_logic #(.SPEED_W(SW), .DEV_W(DW), .REF_W(RW)) dut (
      .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .position_direction_select(term[0]), .position_direction_code(dir_c),
      .homing_switch_input(term[1]), .homing_switch_code(home_c),
      .emergency_halt_input(term[2]), .emergency_halt_code(halt_c),
      .deviation_clear_input(term[3]), .deviation_clear_code(clr_c),
      .speed_limit_source_select(term[4]), .speed_limit_source_code(sls_c),
      .pulse_input_block(term[5]), .pulse_input_block_code(blk_c),
      .speed_limit_source_mode(sl_mode), .speed_limit_first(lim_a),
      .speed_limit_second(lim_b), .position_mode(pos_mode),
      .position_ref_source(ref_src), .pulse_step_in(pulse), .position_ref_in(ref_in),
      .deviation_delta(delta), .servo_on_possible(sop), .fault_class1(f1),
      .fault_class2(f2), .motor_speed(speed), .rotation_threshold(thr),
      .position_ref_out_q(ref_out), .homing_triggered_q(home_q), .halt_decel_q(decel_q),
      .position_lock_q(lock_q), .deviation_accum_q(acc_q), .deviation_cleared_q(clr_q),
      .internal_speed_limit_q(lim_q), .speed_limit_from_terminal_q(lim_t),
      .pulse_accept_q(acc_p), .servo_ready_q(rdy_q), .motor_rotating_output(rot)
   );
   field_terminal_model far_side (.core_clk(core_clk), .nrst(nrst), .want(want), .term(term));
   // ****
   // clock, watchdog, pulse counters
   // ****
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         final_report();
      end
   end
   always @(negedge core_clk) begin
      if (clr_q === 1'h1) n_clr++;
      if (acc_p === 1'h1) n_acc++;
   end
   // ****
   // expectation functions
   // ****
   function automatic logic lvl(input servo_io_pkg::logic_code_t c, input logic r);
      return (c == 3'h0) ? !r : (c == 3'h1) ? r : 1'h0;
   endfunction : lvl
   function automatic logic home_exp(input servo_io_pkg::logic_code_t c, input logic r);
      return lvl((c == 3'h2) ? 3'h1 : (c == 3'h3 || c == 3'h4) ? 3'h0 : c, r);
   endfunction : home_exp
   function automatic logic clr_exp(input servo_io_pkg::logic_code_t c, input logic rise);
      servo_io_pkg::logic_code_t e;
      e = (c == 3'h1) ? 3'h2 : (c == 3'h0) ? 3'h3 : c;
      return (e == 3'h2 && rise) || (e == 3'h3 && !rise) || (e == 3'h4);
   endfunction : clr_exp
   function automatic logic rot_exp(input logic signed [SW-1:0] s, input logic [SW-1:0] t);
      int a;
      a = s;
      if (a < 0) a = -a;
      return a > int'(t);
   endfunction : rot_exp
   // ****
   // shared tasks
   // ****
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic settle();
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
   endtask : settle
   task automatic final_report();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   // ****
   // main sequence
   // ****
   initial begin
      void'($urandom(32'he065));
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      check("ready in reset", rdy_q, 1'h0);
      @(posedge core_clk) nrst <= 1'h1;
      // every home code at both contact levels
      for (int k = 0; k < 16; k++) begin
         @(posedge core_clk);
         home_c <= 3'(k >> 1);
         want[1] <= k[0];
         settle();
         check("home", home_q, home_exp(3'(k >> 1), k[0]));
      end
      $display("test home done");
      for (int k = 0; k < 12; k++) begin
         @(posedge core_clk);
         dir_c <= 3'(k % 2);
         want[0] <= 1'($urandom());
         ref_in <= $urandom();
         settle();
         check("direction", ref_out, RW'(lvl(dir_c, want[0]) ? ref_in : -ref_in));
      end
      $display("test direction done");
      // zero, load a known sum, then try each clear code on both edges
      for (int c = 0; c < 8; c++) begin
         @(posedge core_clk);
         clr_c <= 3'h2;
         want[3] <= 1'h1;
         settle();
         @(posedge core_clk) want[3] <= 1'h0;
         settle();
         check("clear zero", acc_q, 32'h0000_0000);
         @(posedge core_clk) delta <= 32'h0000_0007;
         repeat (3) @(posedge core_clk);
         delta <= 32'h0000_0000;
         exp_acc = 32'h0000_0015;
         clr_c <= 3'(c);
         settle();
         for (int e2 = 1; e2 >= 0; e2--) begin
            @(posedge core_clk);
            n_clr = 0;
            want[3] <= 1'(e2);
            settle();
            if (clr_exp(3'(c), 1'(e2))) exp_acc = 32'h0000_0000;
            check("clear sum", acc_q, exp_acc);
            check("clear pulses", n_clr, clr_exp(3'(c), 1'(e2)));
         end
      end
      $display("test clear done");
      @(posedge core_clk);
      {sop, f1, f2} <= 3'h4;
      speed <= 16'h0100;
      thr <= 16'h0010;
      want[2] <= 1'h1;
      settle();
      check("halt stopping", decel_q, 1'h1);
      check("halt early lock", lock_q, 1'h0);
      check("ready in halt", rdy_q, 1'h0);
      @(posedge core_clk) speed <= 16'h0000;
      settle();
      check("halt stop end", decel_q, 1'h0);
      check("halt lock", lock_q, 1'h1);
      @(posedge core_clk) want[2] <= 1'h0;
      settle();
      check("halt release", lock_q, 1'h0);
      check("ready after halt", rdy_q, 1'h1);
      $display("test halt done");
      for (int k = 0; k < 16; k++) begin
         @(posedge core_clk) {sop, f1, f2} <= 3'($urandom());
         settle();
         check("ready", rdy_q, sop && !f1 && !f2);
      end
      $display("test ready done");
      // threshold boundaries first, then random speeds
      for (int k = 0; k < 16; k++) begin
         tv = SW'($urandom_range(32000));
         sv = SW'($urandom());
         if (k == 0) sv = tv;
         if (k == 1) sv = tv + 16'h0001;
         if (k == 2) sv = -tv;
         if (k == 3) sv = -(tv + 16'h0001);
         @(posedge core_clk);
         thr <= tv;
         speed <= sv;
         settle();
         check("rotation", rot, rot_exp(sv, tv));
      end
      $display("test rotation done");
      for (int k = 0; k < 16; k++) begin
         @(posedge core_clk);
         sl_mode <= 3'(k >> 1);
         want[4] <= k[0];
         lim_a <= SW'($urandom());
         lim_b <= SW'($urandom());
         settle();
         e_lim = lvl(sls_c, want[4]) ? -lim_a : -lim_b;
         if (sl_mode != 3'h2) e_lim = 16'h0000;
         check("limit", lim_q, e_lim);
         check("limit source", lim_t, sl_mode == 3'h2);
      end
      $display("test limit done");
      for (int k = 0; k < 16; k++) begin
         @(posedge core_clk);
         pos_mode <= k[0];
         ref_src <= 2'(k >> 1);
         want[5] <= k[3];
         settle();
         @(posedge core_clk);
         n_acc = 0;
         pulse <= 1'h1;
         @(posedge core_clk) pulse <= 1'h0;
         repeat (3) @(negedge core_clk);
         check("accept", n_acc, !(k[0] && k[3] && k[2:1] == 2'h0));
      end
      $display("test pulse block done");
      // clock enable low freezes every flop, synchronisers included
      @(posedge core_clk);
      dir_c <= 3'h1;
      want[0] <= 1'h1;
      ref_in <= 32'h0000_1234;
      settle();
      @(posedge core_clk);
      clk_en <= 1'h0;
      ref_in <= 32'h0000_5678;
      delta <= 32'h0000_0003;
      want[0] <= 1'h0;
      settle();
      check("frozen ref", ref_out, 32'h0000_1234);
      check("frozen sum", acc_q, exp_acc);
      // release the enable, terminal change then passes through
      @(posedge core_clk);
      clk_en <= 1'h1;
      delta <= 32'h0000_0000;
      settle();
      check("thawed ref", ref_out, RW'(lvl(dir_c, want[0]) ? ref_in : -ref_in));
      check("thawed sum", acc_q, exp_acc);
      $display("test clock enable done");
      final_report();
   end
endmodule : servo_io_function_logic_tb_top
